//--- design/rxd_pkg.sv
// shared constants and types for the receive descriptor dma ends
package rxd_pkg;
   // =======================================================
   // descriptor layout, byte offsets within one descriptor
   localparam logic [31:0] RXD_W0_OFS = 32'h0000_0000;
   localparam logic [31:0] RXD_W1_OFS = 32'h0000_0004;
   localparam logic [31:0] RXD_DESC_BYTES = 32'h0000_0010;
   localparam logic [31:0] RXD_WORD_BYTES = 32'h0000_0004;
   localparam logic [10:0] RXD_WORD_BYTES_11 = 11'h004;
   localparam logic [13:0] RXD_WORD_BYTES_14 = 14'h0004;
   // =======================================================
   // status word fields
   localparam int RXD_OWN_BIT = 31;
   localparam int RXD_LEN_LSB = 16;
   localparam int RXD_LEN_W = 14;
   localparam int RXD_FS_BIT = 9;
   localparam int RXD_LS_BIT = 8;
   // =======================================================
   // control word fields
   localparam int RXD_BS_W = 11;
   localparam int RXD_BS1_LSB = 0;
   localparam int RXD_BS2_LSB = 11;
   localparam int RXD_CHAIN_BIT = 24;
   localparam int RXD_END_RING_BIT = 25;
   // =======================================================
   // bus control register skip length field
   localparam int RXD_SKIP_LSB = 2;
   localparam int RXD_SKIP_W = 5;
   localparam int RXD_SKIP_SHIFT = 2;
   // =======================================================
   // descriptor fetch word indices
   localparam logic [1:0] RXD_IDX_STATUS = 2'h0;
   localparam logic [1:0] RXD_IDX_CTRL = 2'h1;
   localparam logic [1:0] RXD_IDX_BUF1 = 2'h2;
   localparam logic [1:0] RXD_IDX_LAST = 2'h3;
   // =======================================================
   // receive dma states
   typedef enum logic [6:0] {
      RXD_IDLE = 7'h01,
      RXD_FETCH = 7'h02,
      RXD_SUSP = 7'h04,
      RXD_DATA = 7'h08,
      RXD_STAT = 7'h10,
      RXD_STATF = 7'h20,
      RXD_NEXT = 7'h40
   } rxd_state_t;
endpackage : rxd_pkg

//--- design/rxd_mem_if.sv
// word bus between the receive dma master and host memory
interface rxd_mem_if;
   logic memReq;
   logic memWe;
   logic [31:0] memAddr;
   logic [31:0] memWdata;
   logic memAck;
   logic [31:0] memRdata;
   modport dev (
      output memReq,
      output memWe,
      output memAddr,
      output memWdata,
      input memAck,
      input memRdata
   );
   modport mem (
      input memReq,
      input memWe,
      input memAddr,
      input memWdata,
      output memAck,
      output memRdata
   );
endinterface : rxd_mem_if

//--- design/rxd_host_mem.sv
// host memory end: word store answering single 32-bit master accesses
module rxd_host_mem
   import rxd_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   rxd_mem_if.mem bus,
   input wire logic swWe,
   input wire logic [31:0] swAddr,
   input wire logic [31:0] swWdata,
   output logic [31:0] swRdata
);
   localparam int DEPTH = 1 << ADDR_W;

   typedef struct packed {
      logic [DEPTH-1:0][31:0] mem;
      logic ack;
      logic [31:0] rdata;
      logic [31:0] swRd;
   } rxd_mem_state_t;

   rxd_mem_state_t s_reg;
   rxd_mem_state_t s_next;
   logic [ADDR_W-1:0] busIdx;
   logic [ADDR_W-1:0] swIdx;

   assign busIdx = bus.memAddr[RXD_SKIP_SHIFT +: ADDR_W];
   assign swIdx = swAddr[RXD_SKIP_SHIFT +: ADDR_W];

   // =======================================================
   // access logic
   always_comb begin
      s_next = s_reg;
      // one answer per request; the held request during ack is not new
      s_next.ack = bus.memReq && !s_reg.ack;
      if (bus.memReq && !s_reg.ack) begin
         if (bus.memWe) begin
            s_next.mem[busIdx] = bus.memWdata; // (RULE16)
         end else begin
            s_next.rdata = s_reg.mem[busIdx]; // (RULE16)
         end
      end
      // software writes last so a descriptor hand-back is never lost
      if (swWe) begin
         s_next.mem[swIdx] = swWdata; // (RULE4)
      end
      s_next.swRd = s_next.mem[swIdx];
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus.memAck = s_reg.ack;
   assign bus.memRdata = s_reg.rdata;
   assign swRdata = s_reg.swRd;
endmodule : rxd_host_mem

//--- design/rxd_dma.sv
// receive descriptor dma engine: mac stream to host memory buffers
// Function
// (RULE1) move buffered receive data to host memory
// (RULE2) start transfer when mac requests it
// (RULE3) write frame status into descriptor
// (RULE4) host lays descriptors as four long words
// (RULE5) first word holds reception status
// (RULE6) second word: structure type and buffer size
// (RULE7) last two words: buffer and next addresses
// (RULE8) frame may span descriptors and buffers
// (RULE9) ring, chain or mixed lists accepted
// (RULE10) ring descriptor points to two buffers
// (RULE11) host places ring descriptors back to back
// (RULE12) ring next uses skip length field
// (RULE13) first descriptor from list base input
// (RULE14) chained descriptor: one buffer, next pointer
// (RULE15) after last descriptor wrap to first
// (RULE16) 32-bit single reads and writes
module rxd_dma
   import rxd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   rxd_mem_if.dev bus,
   input wire logic [31:0] rxDescriptorListBase,
   input wire logic [31:0] busControlRegister,
   input wire logic pollDemand,
   input wire logic rxValid,
   input wire logic [31:0] rxData,
   input wire logic rxLast,
   input wire logic rxBad,
   output logic rxReady,
   output logic frameDone,
   output logic [RXD_LEN_W-1:0] frameLen,
   output logic suspended
);
   typedef struct packed {
      rxd_state_t st;
      logic started;
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] wIdx;
      logic [31:0] cur;
      logic [31:0] first;
      logic [31:0] ctrl;
      logic [31:0] buf1;
      logic [31:0] wordThree;
      logic [31:0] bufPtr;
      logic onBuf2;
      logic [RXD_BS_W-1:0] rem;
      logic inFrame;
      logic frameEnd;
      logic [RXD_LEN_W-1:0] len;
      logic [1:0][33:0] fifo;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      logic rdy;
      logic done;
      logic susp;
   } rxd_dma_state_t;

   rxd_dma_state_t s_reg, s_next;

   logic push, pop;
   logic [33:0] head;
   logic chain, endRing;
   logic [RXD_BS_W-1:0] size1, size2;
   logic [31:0] skipBytes, ringNext;

   assign head = s_reg.fifo[s_reg.rp];
   assign chain = s_reg.ctrl[RXD_CHAIN_BIT];
   assign endRing = s_reg.ctrl[RXD_END_RING_BIT];
   assign size1 = s_reg.ctrl[RXD_BS1_LSB +: RXD_BS_W];
   assign size2 = s_reg.ctrl[RXD_BS2_LSB +: RXD_BS_W];
   assign skipBytes = 32'(busControlRegister[RXD_SKIP_LSB +: RXD_SKIP_W])
      << RXD_SKIP_SHIFT;
   assign ringNext = s_reg.cur + RXD_DESC_BYTES + skipBytes; // (RULE12)

   // status word built from the running frame length
   function automatic logic [31:0] statusWord(
      input logic [RXD_LEN_W-1:0] n,
      input logic fs,
      input logic ls
   );
      logic [31:0] w;
      w = '0;
      w[RXD_LEN_LSB +: RXD_LEN_W] = n;
      w[RXD_FS_BIT] = fs;
      w[RXD_LS_BIT] = ls;
      return w; // own bit left clear hands the descriptor back
   endfunction : statusWord

   // =======================================================
   // two-entry buffer and dma sequencing
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      pop = 1'b0;
      push = rxValid && s_reg.rdy;
      unique case (s_reg.st)
         RXD_IDLE: begin
            if (!s_reg.started) begin
               s_next.started = 1'b1;
               s_next.cur = rxDescriptorListBase; // (RULE13)
            end else if (s_reg.cnt != 2'h0) begin
               s_next.st = RXD_FETCH; // (RULE2)
               s_next.req = 1'b1;
               s_next.we = 1'b0;
               s_next.wIdx = RXD_IDX_STATUS;
               s_next.addr = s_reg.cur + RXD_W0_OFS;
            end
         end
         RXD_FETCH: begin
            if (bus.memAck) begin
               s_next.wIdx = s_reg.wIdx + 2'h1;
               s_next.addr = s_reg.addr + RXD_WORD_BYTES; // (RULE16)
               unique case (s_reg.wIdx)
                  RXD_IDX_STATUS: begin
                     if (!bus.memRdata[RXD_OWN_BIT]) begin
                        s_next.st = RXD_SUSP;
                        s_next.req = 1'b0;
                        s_next.susp = 1'b1;
                     end
                  end
                  RXD_IDX_CTRL: s_next.ctrl = bus.memRdata; // (RULE6)
                  RXD_IDX_BUF1: s_next.buf1 = bus.memRdata; // (RULE7)
                  RXD_IDX_LAST: begin
                     s_next.wordThree = bus.memRdata; // (RULE7)
                     s_next.req = 1'b0;
                     s_next.st = RXD_DATA;
                     s_next.bufPtr = s_reg.buf1;
                     s_next.rem = size1;
                     s_next.onBuf2 = 1'b0;
                     if (!s_reg.inFrame) begin
                        s_next.inFrame = 1'b1;
                        s_next.first = s_reg.cur;
                        s_next.len = '0;
                     end
                  end
               endcase
            end
         end
         RXD_SUSP: begin
            // waits for software to hand descriptors back
            if (pollDemand) begin
               s_next.susp = 1'b0;
               s_next.st = RXD_FETCH;
               s_next.req = 1'b1;
               s_next.wIdx = RXD_IDX_STATUS;
               s_next.addr = s_reg.cur + RXD_W0_OFS;
            end
         end
         RXD_DATA: begin
            if (s_reg.req) begin
               if (bus.memAck) begin
                  pop = 1'b1; // (RULE1)
                  s_next.req = 1'b0;
                  s_next.bufPtr = s_reg.bufPtr + RXD_WORD_BYTES;
                  s_next.rem = (s_reg.rem > RXD_WORD_BYTES_11) ?
                     s_reg.rem - RXD_WORD_BYTES_11 : '0;
                  s_next.len = s_reg.len + RXD_WORD_BYTES_14;
                  if (head[32] && head[33]) begin
                     // bad frame: reuse the same descriptors
                     s_next.cur = s_reg.first;
                     s_next.inFrame = 1'b0;
                     s_next.st = RXD_IDLE;
                  end else if (head[32]) begin
                     s_next.frameEnd = 1'b1;
                     s_next.st = RXD_STAT; // (RULE3)
                     s_next.req = 1'b1;
                     s_next.we = 1'b1;
                     s_next.addr = s_reg.cur + RXD_W0_OFS; // (RULE5)
                     s_next.wdata = statusWord(s_next.len,
                        s_reg.first == s_reg.cur, 1'b1);
                  end
               end
            end else if (s_reg.rem == '0) begin
               if (!s_reg.onBuf2 && !chain && size2 != '0) begin
                  s_next.onBuf2 = 1'b1; // (RULE10)
                  s_next.bufPtr = s_reg.wordThree;
                  s_next.rem = size2;
               end else begin
                  // buffers full mid-frame: release and move on (RULE8)
                  s_next.st = RXD_STAT;
                  s_next.req = 1'b1;
                  s_next.we = 1'b1;
                  s_next.addr = s_reg.cur + RXD_W0_OFS; // (RULE5)
                  s_next.wdata = statusWord(s_reg.len,
                     s_reg.first == s_reg.cur, 1'b0);
               end
            end else if (s_reg.cnt != 2'h0) begin
               s_next.req = 1'b1;
               s_next.we = 1'b1;
               s_next.addr = s_reg.bufPtr;
               s_next.wdata = head[31:0]; // (RULE16)
            end
         end
         RXD_STAT: begin
            if (bus.memAck) begin
               // final status is copied into the frame's first descriptor
               if (s_reg.frameEnd && s_reg.first != s_reg.cur) begin
                  s_next.st = RXD_STATF; // (RULE3)
                  s_next.addr = s_reg.first + RXD_W0_OFS;
                  s_next.wdata[RXD_FS_BIT] = 1'b1;
               end else begin
                  s_next.req = 1'b0;
                  s_next.we = 1'b0;
                  s_next.st = RXD_NEXT;
               end
            end
         end
         RXD_STATF: begin
            if (bus.memAck) begin
               s_next.req = 1'b0;
               s_next.we = 1'b0;
               s_next.st = RXD_NEXT;
            end
         end
         RXD_NEXT: begin
            if (endRing) begin
               s_next.cur = rxDescriptorListBase; // (RULE15)
            end else if (chain) begin
               s_next.cur = s_reg.wordThree; // (RULE14)
            end else begin
               s_next.cur = ringNext; // (RULE9)
            end
            if (s_reg.frameEnd) begin
               s_next.frameEnd = 1'b0;
               s_next.inFrame = 1'b0;
               s_next.done = 1'b1;
               s_next.st = RXD_IDLE;
            end else begin
               s_next.st = RXD_FETCH; // (RULE8)
               s_next.req = 1'b1;
               s_next.wIdx = RXD_IDX_STATUS;
               s_next.addr = s_next.cur + RXD_W0_OFS;
            end
         end
      endcase
      if (push) begin
         s_next.fifo[s_reg.wp] = {rxBad, rxLast, rxData};
         s_next.wp = ~s_reg.wp;
      end
      if (pop) begin
         s_next.rp = ~s_reg.rp;
      end
      s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
      // ready registered from the next fill so the mac sees a flop
      s_next.rdy = (s_next.cnt == 2'h0) ||
         (s_next.cnt == 2'h1 && !push);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
         s_reg.st <= RXD_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus.memReq = s_reg.req;
   assign bus.memWe = s_reg.we;
   assign bus.memAddr = s_reg.addr;
   assign bus.memWdata = s_reg.wdata;
   assign rxReady = s_reg.rdy;
   assign frameDone = s_reg.done;
   assign frameLen = s_reg.len;
   assign suspended = s_reg.susp;
endmodule : rxd_dma

//--- test/rxd_mem_checker.sv
// concurrent checks on the word bus between dma master and host memory
module rxd_mem_checker (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [31:0] memAddr,
   input wire logic [31:0] memWdata,
   input wire logic memAck,
   input wire logic [31:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // =======================================================
   // single word handshake
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   sequence wordAnswer;
      ##1 memAck ##1 !memAck;
   endsequence

   a_word_cycle: assert property (memReq && !memAck |-> wordAnswer)
      else $error("answer not a one cycle pulse after request");
   a_req_until_ack: assert property (memReq && !memAck |=> memReq)
      else $error("request dropped before answer");
   a_ack_cause: assert property ($rose(memAck) |-> $past(memReq))
      else $error("answer without request");
   a_ack_idle: assert property (!memReq && !memAck |=> !memAck)
      else $error("answer while bus idle");
   a_addr_stable: assert property (
      memReq && !memAck |=> $stable(memAddr))
      else $error("address moved while waiting");
   a_dir_stable: assert property (
      memReq && !memAck |=> $stable(memWe))
      else $error("direction moved while waiting");
   a_wdata_stable: assert property (
      memReq && memWe && !memAck |=> $stable(memWdata))
      else $error("write data moved while waiting");
   a_addr_aligned: assert property (memReq |-> memAddr[1:0] == 2'h0)
      else $error("unaligned word address");

   // =======================================================
   // main traffic kinds
   c_read: cover property (memReq && !memWe && !memAck ##1 memAck);
   c_write: cover property (memReq && memWe && !memAck ##1 memAck);
   c_back2back: cover property (memAck && memReq ##2 memAck);
endmodule : rxd_mem_checker

//--- test/testbench.sv
// self-checking bench: ring, wrap with suspend, chain with bad frame
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, arst_n, pollDemand, rxValid, rxLast, rxBad, swWe;
   logic [31:0] listBase, rxData, swAddr, swWdata, swRdata, seed;
   logic [31:0] busCtrl;
   logic rxReady, frameDone, suspended;
   logic [13:0] frameLen;
   int errors, cmpCount;
   logic [31:0] expMem [logic [31:0]];
   logic [31:0] addrQ [$];
   logic [13:0] lenQ [$];

   rxd_mem_if memBus ();
   rxd_dma u_rxd_dma (.sys_clk(sys_clk), .arst_n(arst_n), .bus(memBus),
      .rxDescriptorListBase(listBase),
      .busControlRegister(busCtrl),
      .pollDemand(pollDemand), .rxValid(rxValid), .rxData(rxData),
      .rxLast(rxLast), .rxBad(rxBad), .rxReady(rxReady),
      .frameDone(frameDone), .frameLen(frameLen), .suspended(suspended));
   rxd_host_mem #(.ADDR_W(8)) u_rxd_host_mem (.sys_clk(sys_clk),
      .arst_n(arst_n), .bus(memBus), .swWe(swWe), .swAddr(swAddr),
      .swWdata(swWdata), .swRdata(swRdata));
   rxd_mem_checker u_rxd_mem_checker (.sys_clk(sys_clk), .arst_n(arst_n),
      .memReq(memBus.memReq), .memWe(memBus.memWe),
      .memAddr(memBus.memAddr), .memWdata(memBus.memWdata),
      .memAck(memBus.memAck), .memRdata(memBus.memRdata));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // =======================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task end_of_test();
      $display("comparisons %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task doReset();
      arst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      arst_n = 1'b1;
      @(negedge sys_clk);
   endtask : doReset

   // strobe stays up between words; callers lower it
   task swr(input logic [31:0] a, input logic [31:0] d);
      swWe = 1'b1;
      swAddr = a;
      swWdata = d;
      @(negedge sys_clk);
   endtask : swr

   task wdesc(input logic [31:0] a, input logic [31:0] w1,
      input logic [31:0] w2, input logic [31:0] w3);
      swr(a, 32'h8000_0000);
      swr(a + 32'h4, w1);
      swr(a + 32'h8, w2);
      swr(a + 32'hc, w3);
      swWe = 1'b0;
      @(negedge sys_clk);
   endtask : wdesc

   // valid stays up across words so the buffer sees back-to-back traffic
   task sendFrame(input int n, input logic bad);
      if (!bad) lenQ.push_back(14'(n * 4));
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         rxValid = 1'b1;
         rxData = seed;
         rxLast = (i == n - 1);
         rxBad = bad && (i == n - 1);
         expMem[addrQ.pop_front()] = seed;
         do @(posedge sys_clk); while (rxReady !== 1'b1);
         @(negedge sys_clk);
      end
      rxValid = 1'b0;
      rxLast = 1'b0;
      rxBad = 1'b0;
      // one idle cycle so a following frame never re-raises valid at once
      @(negedge sys_clk);
   endtask : sendFrame

   task verify(input string name);
      for (int i = 0; i < 400 && lenQ.size() != 0; i++) @(negedge sys_clk);
      check(32'(lenQ.size()), 32'h0);
      foreach (expMem[a]) begin
         swAddr = a;
         @(negedge sys_clk);
         check(swRdata, expMem[a]);
      end
      expMem.delete();
      $display("test %s done", name);
   endtask : verify

   // =======================================================
   // frame completion watcher
   // mid-cycle look, where the one-cycle pulse has settled
   always @(negedge sys_clk) begin
      if (frameDone === 1'b1) begin
         if (lenQ.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            check({18'h0, frameLen}, {18'h0, lenQ.pop_front()});
         end
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      end_of_test();
   end

   // =======================================================
   // main sequence
   initial begin
      arst_n = 1'b0;
      pollDemand = 1'b0;
      rxValid = 1'b0;
      rxData = 32'h0;
      rxLast = 1'b0;
      rxBad = 1'b0;
      swWe = 1'b0;
      swAddr = 32'h0;
      swWdata = 32'h0;
      listBase = 32'h0;
      busCtrl = 32'h0000_0008;
      seed = 32'haaeed38f;
      errors = 0;
      cmpCount = 0;
      doReset();
      // skip of two words puts the second ring entry at 0x18
      wdesc(32'h000, 32'h0000_2008, 32'h200, 32'h240);
      wdesc(32'h018, 32'h0200_4008, 32'h280, 32'h2c0);
      addrQ = '{32'h200, 32'h204, 32'h240};
      expMem[32'h000] = 32'h000c_0300;
      sendFrame(3, 1'b0);
      verify("ring two buffers");
      // first entry was handed back, so the wrap must stall
      addrQ = '{32'h280, 32'h284, 32'h2c0, 32'h2c4, 32'h200};
      expMem[32'h018] = 32'h0014_0300;
      // last descriptor of the frame keeps its own status copy
      expMem[32'h000] = 32'h0014_0100;
      sendFrame(5, 1'b0);
      for (int i = 0; i < 400 && suspended !== 1'b1; i++) @(negedge sys_clk);
      check({31'h0, suspended}, 32'h1);
      swr(32'h000, 32'h8000_0000);
      swWe = 1'b0;
      pollDemand = 1'b1;
      @(negedge sys_clk);
      pollDemand = 1'b0;
      verify("ring wrap");
      listBase = 32'h100;
      doReset();
      wdesc(32'h100, 32'h0100_0008, 32'h300, 32'h140);
      wdesc(32'h140, 32'h0300_0008, 32'h340, 32'h000);
      addrQ = '{32'h300};
      sendFrame(1, 1'b1);
      // bad frame leaves descriptors for reuse, no status
      addrQ = '{32'h300, 32'h304, 32'h340};
      expMem[32'h100] = 32'h000c_0300;
      expMem[32'h140] = 32'h000c_0100;
      sendFrame(3, 1'b0);
      verify("chain after bad frame");
      end_of_test();
   end
endmodule : testbench
